// *** rtl/hws_cfg.svh ***
// Constants of the heater, watchdog and standby block.
// Assumes it is included by bare name from rtl/ sources; definitions only.
`ifndef HWS_CFG_SVH
`define HWS_CFG_SVH

// APB register byte offsets.
`define HWS_OFS_HEAT_CTRL 12'h000
`define HWS_OFS_MODE_CTRL 12'h004
`define HWS_OFS_STATUS 12'h008
`define HWS_OFS_WDOG_LEFT 12'h00C
`define HWS_ADDR_W 12

// Heater control register fields.
`define HWS_HEAT_REQ_BIT 6
`define HWS_WDOG_EN_BIT 5
`define HWS_PWR_SEL_BIT 0

// Mode control register: seven bits, standby when the upper five match.
`define HWS_MODE_W 7
`define HWS_MODE_RST 7'h00
`define HWS_STBY_HI 6
`define HWS_STBY_LO 2
`define HWS_STBY_CODE 5'h01

// Status register fields.
`define HWS_ST_HEATING 0
`define HWS_ST_TIMED 1
`define HWS_ST_EXPIRED 2
`define HWS_ST_OSC_RUN 3
`define HWS_ST_STANDBY 4

// Timing: clock period, oscillator tick and watchdog period.
`define HWS_CLK_NS 50
`define HWS_TICK_NS 1000000
`define HWS_WDOG_TYP_MS 4000
`define HWS_WDOG_MIN_MS 2000
`define HWS_WDOG_MAX_MS 7000
`define HWS_TICK_CYC (`HWS_TICK_NS / `HWS_CLK_NS)
`define HWS_NS_PER_MS 1000000
`define HWS_CNT_W 16

`endif

// *** rtl/hws_pkg.sv ***
// Types shared by the heater, watchdog and standby block.
// Assumes hws_cfg.svh supplies the field widths.
`default_nettype none
`include "hws_cfg.svh"

package hws_pkg;

  // Heater state: off, heating until host clears, or heating under watchdog.
  typedef enum logic [1:0] {
    HWS_HEAT_OFF = 2'b00,
    HWS_HEAT_FREE = 2'b01,
    HWS_HEAT_TIMED = 2'b10
  } hws_heat_e;

  typedef logic [`HWS_CNT_W-1:0] hws_cnt_t;

endpackage
`default_nettype wire

// *** rtl/hws_tick_div.sv ***
// Divider that stands in for the local oscillator: one-cycle tick pulses.
// Assumes a single pclk domain; run low freezes the count, as a stopped oscillator.
`timescale 1ns/100ps
`default_nettype none
`include "hws_cfg.svh"

module hws_tick_div #(
  parameter int DIV = `HWS_TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic tick
);
  import hws_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
  } hws_div_s;

  hws_div_s st_q;
  hws_div_s st_d;

  // A divide by one would make the tick a constant level, not a pulse.
  generate
    if (DIV < 2)
    begin : g_chk
      $error("hws_tick_div: DIV must be at least 2");
    end
  endgenerate

  assign tick = run && (st_q.cnt == 32'(DIV - 1));

  // The count holds while stopped so a restart resumes the same phase.
  always_comb
  begin
    st_d = st_q;
    if (tick)
    begin
      st_d.cnt = 32'h00000000;
    end
    else if (run)
    begin
      st_d.cnt = st_q.cnt + 32'h00000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// *** rtl/hws_wdog_cnt.sv ***
// Watchdog down-counter clocked by oscillator ticks.
// Assumes start is a one-cycle strobe and cancel a strobe or held level, both from logic on pclk.
`timescale 1ns/100ps
`default_nettype none
`include "hws_cfg.svh"

module hws_wdog_cnt #(
  parameter int TICKS = `HWS_WDOG_TYP_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic cancel,
  input wire logic tick,
  output logic active,
  output logic done,
  output hws_pkg::hws_cnt_t left
);
  import hws_pkg::*;

  typedef struct packed {
    logic act;
    hws_cnt_t cnt;
  } hws_wd_s;

  hws_wd_s st_q;
  hws_wd_s st_d;

  // The period must fit the counter and be at least one tick.
  generate
    if (TICKS < 1 || TICKS >= (1 << `HWS_CNT_W))
    begin : g_chk
      $error("hws_wdog_cnt: TICKS out of range");
    end
  endgenerate

  assign active = st_q.act;
  assign left = st_q.cnt;
  // A restart in the same cycle as the last tick suppresses the expiry.
  assign done = st_q.act && tick && !start && !cancel && (st_q.cnt == hws_cnt_t'(1));

  // Start reloads the full period even when already running.
  always_comb
  begin
    st_d = st_q;
    if (start)
    begin
      st_d.act = 1'b1;
      st_d.cnt = hws_cnt_t'(TICKS);
    end
    else if (cancel || done)
    begin
      st_d.act = 1'b0;
      st_d.cnt = '0;
    end
    else if (st_q.act && tick)
    begin
      st_d.cnt = st_q.cnt - hws_cnt_t'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// *** rtl/hws_heat_ctrl.sv ***
// Heater, watchdog and standby control, reached by software over APB.
// Assumes an APB master on pclk; heater outputs drive an analog heater stage.
//
// How it works
// - Heat request bit 6 plus watchdog enable bit 5 start timed heating.
// - Heating period comes from oscillator ticks, typically 4 s, within 2 to 7 s.
// - On watchdog expiry heating stops by itself, no host action needed.
// - Each new heat enable with watchdog enable, outside standby, restarts a full watchdog-timed heating period.
// - Heating power selects one of two presets, 50 mW or 100 mW.
// - Mode control code 00001xx puts the block in standby, oscillator stopped.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "hws_cfg.svh"

module hws_heat_ctrl #(
  parameter int TICK_CYC = `HWS_TICK_CYC,
  parameter int WDOG_TICKS = `HWS_WDOG_TYP_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`HWS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic heater_on,
  output logic heater_power_hi,
  output logic osc_running,
  output logic standby_active
);
  import hws_pkg::*;

  // Control state of this module in one record; the divider and watchdog hold their own.
  // req and wd_en mirror the heater control bits as last written, save that expiry clears req; heat is what
  // the heater really does, which standby and expiry may override.
  typedef struct packed {
    hws_heat_e heat;
    logic req;
    logic wd_en;
    logic pwr_hi;
    logic [`HWS_MODE_W-1:0] mode;
    logic expired;
    logic [31:0] rdata;
    logic err;
  } hws_state_s;

  hws_state_s st_q;
  hws_state_s st_d;

  // Links to the oscillator divider and the watchdog counter.
  logic tick;
  logic wd_active;
  logic wd_done;
  hws_cnt_t wd_left;
  logic wd_start;
  logic wd_cancel;
  logic timed_keep;
  logic in_standby;

  // APB decode and read path.
  logic acc;
  logic setup_rd;
  logic hit;
  logic hit_heat;
  logic hit_mode;
  logic hit_stat;
  logic hit_left;
  logic wr_heat;
  logic wr_mode;
  logic [31:0] rd_mux;
  logic [`HWS_STBY_HI-`HWS_STBY_LO:0] mode_hi;

  // Periods below the typical figure are only for shortened simulations.
  generate
    if (TICK_CYC < 2 || WDOG_TICKS < 1)
    begin : g_chk
      $error("hws_heat_ctrl: TICK_CYC or WDOG_TICKS too small");
    end
  endgenerate

  // A period beyond the maximum would defeat the current limit, so it is refused.
  // Shorter periods pass, since simulations shorten the period on purpose.
  // The product needs 64 bits: the default period alone is four billion ns.
  generate
    if (longint'(TICK_CYC) * longint'(WDOG_TICKS) * longint'(`HWS_CLK_NS)
      > longint'(`HWS_WDOG_MAX_MS) * longint'(`HWS_NS_PER_MS))
    begin : g_chk_max
      $error("hws_heat_ctrl: watchdog period above the maximum");
    end
  endgenerate

  // The oscillator stands in as a divider that is gated off in standby.
  hws_tick_div #(
    .DIV(TICK_CYC)
  ) u_osc (
    .pclk(pclk),
    .presetn(presetn),
    .run(!in_standby),
    .tick(tick)
  );

  // The watchdog counts only oscillator ticks, so a stopped oscillator freezes it.
  // The period is counted in ticks, so its length spreads with the oscillator.
  hws_wdog_cnt #(
    .TICKS(WDOG_TICKS)
  ) u_wdog (
    .pclk(pclk),
    .presetn(presetn),
    .start(wd_start),
    .cancel(wd_cancel),
    .tick(tick),
    .active(wd_active),
    .done(wd_done),
    .left(wd_left)
  );

  // Standby is decoded from the stored mode, ignoring the two low bits.
  assign mode_hi = st_q.mode[`HWS_STBY_HI:`HWS_STBY_LO];
  assign in_standby = (mode_hi == `HWS_STBY_CODE);

  // The slave never stalls: the read word is captured in the setup cycle.
  assign pready = 1'b1;
  // The error flag answers an unmapped word in its access phase only.
  assign pslverr = st_q.err;
  assign prdata = st_q.rdata;
  assign acc = psel && penable;
  assign setup_rd = psel && !penable && !pwrite;

  // Register map, one aligned 32-bit word each:
  //   heater control at offset 0: bit 6 heat request, bit 5 watchdog enable,
  //   bit 0 selects the high power preset.
  //   mode control at offset 4: seven bits; the upper five select standby,
  //   the two low bits are kept but never looked at.
  //   status at offset 8, read only: heating, watchdog running, expired,
  //   oscillator running and standby, from bit 0 upwards.
  //   watchdog remaining at offset 12, read only: ticks left in the period.
  // Writes to the read-only words are dropped without an error; unmapped
  // words read zero and answer with an error.
  // There are no byte strobes, so a partial write always stores the full word.
  // Address decode shared by reads and writes.
  // Misaligned offsets match no word and count as unmapped.
  assign hit_heat = (paddr == `HWS_OFS_HEAT_CTRL);
  assign hit_mode = (paddr == `HWS_OFS_MODE_CTRL);
  assign hit_stat = (paddr == `HWS_OFS_STATUS);
  assign hit_left = (paddr == `HWS_OFS_WDOG_LEFT);
  assign hit = hit_heat || hit_mode || hit_stat || hit_left;
  assign wr_heat = acc && pwrite && hit_heat;
  assign wr_mode = acc && pwrite && hit_mode;

  // Every write of request and enable together reloads the full period.
  // Standby refuses the start, so a frozen watchdog is never armed.
  assign wd_start = wr_heat && pwdata[`HWS_HEAT_REQ_BIT] && pwdata[`HWS_WDOG_EN_BIT]
    && !in_standby;

  // Timed heating lasts only while the watchdog runs or is being started now.
  // A request left set across standby would otherwise heat with no limit at all.
  assign timed_keep = wd_start || (st_q.heat == HWS_HEAT_TIMED && wd_active);

  // Any other heater write, or standby, drops a running watchdog.
  // Cancelling while idle is harmless: the counter simply stays cleared.
  assign wd_cancel = (wr_heat && !wd_start) || (st_q.heat != HWS_HEAT_TIMED) || in_standby;

  // Read multiplexer; unmapped addresses read as zero.
  // Status bits are live, so a read shows the state at its setup cycle.
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      `HWS_OFS_HEAT_CTRL:
      begin
        rd_mux[`HWS_HEAT_REQ_BIT] = st_q.req;
        rd_mux[`HWS_WDOG_EN_BIT] = st_q.wd_en;
        rd_mux[`HWS_PWR_SEL_BIT] = st_q.pwr_hi;
      end
      `HWS_OFS_MODE_CTRL:
      begin
        rd_mux[`HWS_MODE_W-1:0] = st_q.mode;
      end
      `HWS_OFS_STATUS:
      begin
        rd_mux[`HWS_ST_HEATING] = (st_q.heat != HWS_HEAT_OFF);
        rd_mux[`HWS_ST_TIMED] = wd_active;
        rd_mux[`HWS_ST_EXPIRED] = st_q.expired;
        rd_mux[`HWS_ST_OSC_RUN] = !in_standby;
        rd_mux[`HWS_ST_STANDBY] = in_standby;
      end
      `HWS_OFS_WDOG_LEFT:
      begin
        rd_mux[`HWS_CNT_W-1:0] = wd_left;
      end
      default:
      begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Next-state logic: bus effects first, then hardware events.
  // A host write in the expiry cycle wins, so a re-enable is never lost.
  // Read data is captured in the setup cycle, so the access phase never waits
  // and prdata holds still until the next read setup.
  always_comb
  begin
    st_d = st_q;
    st_d.err = 1'b0;
    if (setup_rd)
    begin
      st_d.rdata = rd_mux;
    end
    if (psel && !penable)
    begin
      st_d.err = !hit;
    end
    if (wr_heat)
    begin
      st_d.req = pwdata[`HWS_HEAT_REQ_BIT];
      st_d.wd_en = pwdata[`HWS_WDOG_EN_BIT];
      st_d.pwr_hi = pwdata[`HWS_PWR_SEL_BIT];
      if (pwdata[`HWS_HEAT_REQ_BIT])
      begin
        st_d.expired = 1'b0;
      end
    end
    else if (st_q.heat == HWS_HEAT_TIMED && wd_done)
    begin
      st_d.req = 1'b0;
      st_d.expired = 1'b1;
    end
    if (wr_mode)
    begin
      st_d.mode = pwdata[`HWS_MODE_W-1:0];
    end

    // Heater state follows the stored request and enable.
    unique case (st_q.heat)
      HWS_HEAT_OFF, HWS_HEAT_FREE, HWS_HEAT_TIMED:
      begin
        if (!st_d.req)
        begin
          st_d.heat = HWS_HEAT_OFF;
        end
        else if (!st_d.wd_en)
        begin
          st_d.heat = HWS_HEAT_FREE;
        end
        else if (timed_keep)
        begin
          st_d.heat = HWS_HEAT_TIMED;
        end
        else
        begin
          st_d.heat = HWS_HEAT_OFF;
        end
      end
      default:
      begin
        st_d.heat = HWS_HEAT_OFF;
      end
    endcase

    // Standby never heats: a host that forgot to clear the request
    // would otherwise heat with the watchdog frozen and no limit at all.
    if (in_standby)
    begin
      st_d.heat = HWS_HEAT_OFF;
    end
  end

  // Reset leaves the heater off and the oscillator running, as after power-up.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q.heat <= HWS_HEAT_OFF;
      st_q.req <= 1'b0;
      st_q.wd_en <= 1'b0;
      st_q.pwr_hi <= 1'b0;
      st_q.mode <= `HWS_MODE_RST;
      st_q.expired <= 1'b0;
      st_q.rdata <= 32'h00000000;
      st_q.err <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Heater outputs come straight from state flip-flops.
  // The power level is only a select flag: the two presets themselves are set
  // by the analog heater stage, and the flag may change while heating.
  assign heater_on = (st_q.heat != HWS_HEAT_OFF);
  assign heater_power_hi = st_q.pwr_hi;
  assign osc_running = !in_standby;
  assign standby_active = in_standby;
endmodule
`default_nettype wire

// *** verif/hws_heat_ctrl_asserts.sv ***
// Port checks for the heater, watchdog and standby block.
// Assumes the block top with pclk and presetn; attached by the bind at the foot.
`timescale 1ns/100ps
`default_nettype none
`include "hws_cfg.svh"
module hws_heat_ctrl_asserts #(
  parameter int TICK_CYC = 4,
  parameter int WDOG_TICKS = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic heater_on,
  input wire logic heater_power_hi,
  input wire logic osc_running,
  input wire logic standby_active
);
  // Slack covers the free-running tick phase and the write latency.
  localparam int MINC = (WDOG_TICKS - 1) * TICK_CYC - 1;
  localparam int MAXC = WDOG_TICKS * TICK_CYC + 3;
  logic wr_heat;
  logic timed_q;
  logic timed_d;
  int cnt_q;
  int cnt_d;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign wr_heat = psel && penable && pwrite && paddr == `HWS_OFS_HEAT_CTRL;
  // Cycles since the last heater write; a mode write drops the bound, as standby ends it.
  always_comb
  begin
    timed_d = timed_q;
    cnt_d = (cnt_q < 1000) ? cnt_q + 1 : cnt_q;
    if (psel && penable && pwrite && paddr == `HWS_OFS_MODE_CTRL)
    begin
      timed_d = 1'b0;
    end
    if (wr_heat)
    begin
      timed_d = pwdata[6:5] == 2'b11 && !standby_active;
      cnt_d = 0;
    end
  end
  // Registers of the helper.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timed_q <= 1'b0;
      cnt_q <= 0;
    end
    else
    begin
      timed_q <= timed_d;
      cnt_q <= cnt_d;
    end
  end
  sequence heat_wr;
    psel && penable && pwrite && paddr == `HWS_OFS_HEAT_CTRL;
  endsequence
  sequence mode_wr;
    psel && penable && pwrite && paddr == `HWS_OFS_MODE_CTRL;
  endsequence
  a_timed_start: assert property (heat_wr ##0 (pwdata[6:5] == 2'b11 && !standby_active) |=> heater_on)
    else $error("timed heating did not start");
  a_clear_off: assert property (heat_wr ##0 !pwdata[6] |=> !heater_on)
    else $error("heater stayed on after clear");
  a_standby_off: assert property (standby_active ##1 standby_active |-> !heater_on)
    else $error("heater on in standby");
  a_mode_decode: assert property (mode_wr ##0 pwdata[6:2] == 5'h01 |=> standby_active && !osc_running)
    else $error("standby code not taken");
  a_power_sel: assert property (heat_wr ##0 pwdata[0] |=> heater_power_hi)
    else $error("high power not selected");
  a_wdog_bound: assert property (heater_on && timed_q |-> cnt_q <= MAXC)
    else $error("watchdog period too long");
  a_wdog_early: assert property ($fell(heater_on) && timed_q |-> cnt_q >= MINC)
    else $error("watchdog period too short");
  a_err_decode: assert property (psel && penable |-> pslverr == !(paddr inside
    {`HWS_OFS_HEAT_CTRL, `HWS_OFS_MODE_CTRL, `HWS_OFS_STATUS, `HWS_OFS_WDOG_LEFT}))
    else $error("error response wrong");
endmodule
bind hws_heat_ctrl hws_heat_ctrl_asserts #(.TICK_CYC(TICK_CYC), .WDOG_TICKS(WDOG_TICKS))
  hws_heat_ctrl_asserts_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .heater_on(heater_on), .heater_power_hi(heater_power_hi),
  .osc_running(osc_running), .standby_active(standby_active));
`default_nettype wire

// *** verif/hws_host_model.sv ***
// Host controller that programs the block over APB.
// Assumes one pclk domain; every wait for pready is bounded.
`timescale 1ns/100ps
`default_nettype none
module hws_host_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  // Idle bus from time zero.
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer; ok stays low if no answer came, so the caller can stop.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err, output logic ok);
    int n;
    ok = 1'b0;
    q = 32'h0;
    err = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16 && !ok; n++)
    begin
      @(posedge pclk);
      ok = pready;
      q = prdata;
      err = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Released data must not look still valid.
  endtask
  // Heating is cleared first, so the watchdog never runs on a stopped oscillator.
  task automatic go_standby(output logic ok);
    logic [31:0] q;
    logic e;
    logic ok2;
    xfer(1'b1, 12'h000, 32'h0, q, e, ok);
    xfer(1'b1, 12'h004, 32'h7, q, e, ok2);
    ok = ok && ok2;
  endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the heater, watchdog and standby block.
// Assumes the host model drives APB and the checker is bound to the block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int TC = 4;
  localparam int WT = 5;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic heater_on, heater_power_hi, osc_running, standby_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  int n;
  int errors = 0;
  int tests_run = 0;
  // Clock of 50 ns period.
  always #25 pclk = ~pclk;
  hws_heat_ctrl #(.TICK_CYC(TC), .WDOG_TICKS(WT)) hws_heat_ctrl_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .heater_on(heater_on), .heater_power_hi(heater_power_hi),
    .osc_running(osc_running), .standby_active(standby_active));
  hws_host_model hws_host_model_i (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  task automatic test_done();
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compare one value.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus transfer; a missing answer ends the run.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic ok;
    hws_host_model_i.xfer(w, a, d, q, e, ok);
    if (!ok)
    begin
      errors++;
      test_done();
    end
  endtask
  // Heating cycles from a start, bounded; the range allows for the tick phase.
  task automatic timed_len();
    @(negedge pclk);
    n = 0;
    while (heater_on === 1'b1 && n < 60)
    begin
      @(negedge pclk);
      n++;
    end
    chk("period", 32'h1, 32'(n >= (WT - 1) * TC && n <= WT * TC + 2));
    if (n >= 60)
    begin
      test_done();
    end
  endtask
  // Reset values, timed heating, expiry and its status.
  task automatic t_timed();
    bus(1'b0, 12'h008, 32'h0);
    chk("status", 32'h8, q);
    bus(1'b1, 12'h000, 32'h61);
    timed_len();
    chk("power", 32'h1, 32'(heater_power_hi));
    bus(1'b0, 12'h000, 32'h0);
    chk("heat_ctrl", 32'h21, q);
    bus(1'b0, 12'h008, 32'h0);
    chk("status", 32'hC, q);
  endtask
  // Rewrite in mid-period restarts it, then free heating until cleared.
  task automatic t_extend();
    bus(1'b1, 12'h000, 32'h60);
    repeat (10) @(negedge pclk);
    bus(1'b1, 12'h000, 32'h60);
    timed_len();
    bus(1'b1, 12'h000, 32'h40);
    repeat (40) @(negedge pclk);
    chk("free", 32'h1, 32'(heater_on));
    bus(1'b1, 12'h000, 32'h0);
    @(negedge pclk);
    chk("off", 32'h0, 32'({heater_on, heater_power_hi}));
  endtask
  // Standby refuses heating; the code with low bits 00 and 11, plus two other codes.
  task automatic t_standby();
    logic ok;
    logic [6:0] m[4] = '{7'h04, 7'h0B, 7'h07, 7'h00};
    hws_host_model_i.go_standby(ok);
    if (!ok)
    begin
      errors++;
      test_done();
    end
    bus(1'b1, 12'h000, 32'h60);
    repeat (4) @(negedge pclk);
    chk("refused", 32'h1, 32'({heater_on, standby_active}));
    bus(1'b1, 12'h004, 32'h0);
    repeat (8) @(negedge pclk);
    chk("no_timer", 32'h0, 32'(heater_on));
    bus(1'b0, 12'h008, 32'h0);
    chk("status", 32'h8, q);
    bus(1'b1, 12'h000, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 12'h004, 32'(m[i]));
      @(negedge pclk);
      chk("standby", 32'(m[i][6:2] == 5'h01), 32'(standby_active));
      chk("osc", 32'(m[i][6:2] != 5'h01), 32'(osc_running));
    end
  endtask
  // Unmapped and read-only places.
  task automatic t_bad();
    bus(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {q[31:1], e});
    bus(1'b0, 12'h002, 32'h0);
    chk("misaligned", 32'h1, {q[31:1], e});
    bus(1'b1, 12'h008, 32'hFF);
    bus(1'b0, 12'h008, 32'h0);
    chk("status_ro", 32'h8, q);
  endtask
  // Reset for 16 cycles, then the scenarios.
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_timed();
    t_extend();
    t_standby();
    t_bad();
    test_done();
  end
endmodule
`default_nettype wire
